// ==== core/serial_command_control.sv ====
/*
  Command register control of the mouse-port serial controller: mode
  select, modem controls, interrupt gating, error flags and line steering.
  Assumes a host port write strobe with data, a single 125 MHz clock and
  events from separate receiver and transmitter cores on the same clock.
*/
// Function
// - bits 7-6 select normal, auto echo, local loopback, remote loopback.
// - bit 5 zero drives request-to-send high and blocks interrupts.
// - interrupt reaches host only while the gating buffer is enabled.
// - bit 4 reads zero; writing one clears parity, framing, overrun flags.
// - bit 2 gates receiver, receive interrupt and receive-ready flag.
// - bit 1 one drives terminal-ready low, zero drives it high.
// - bit 0 gates transmitter, transmit interrupt, transmit-ready flag.
// - overrun stays set until receiver disabled or error reset written.
`timescale 1ns/10ps
`default_nettype none
module serial_command_control
  import serial_command_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire command_write_type cmd_wr,
  input wire logic cmd_rd,
  input wire serial_events_type events,
  input wire logic controller_irq,
  input wire logic tx_serial,
  input wire logic rx_serial,
  output logic [7:0] cmd_rdata,
  output logic [7:0] status_rdata,
  output serial_steer_type steer,
  output logic line_txd,
  output logic rts_n,
  output logic dtr_n,
  output logic host_irq,
  output logic rx_to_core
);

  // ****************************************
  // command register
  // ****************************************
  logic [7:0] command_q;
  logic error_reset;
  logic rx_en;
  logic tx_en;
  op_mode_type mode;

  assign error_reset = cmd_wr.write && cmd_wr.data[error_reset_pos];
  assign rx_en = command_q[receiver_enable_pos];
  assign tx_en = command_q[transmitter_enable_pos];
  assign mode = op_mode_type'(command_q[mode_hi_pos:mode_lo_pos]);

  // the error reset bit is a strobe only, never stored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      command_q <= command_reset;
    end else if (cmd_wr.write) begin
      command_q <= cmd_wr.data & ~(8'h01 << error_reset_pos);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_rdata <= command_reset;
    end else if (cmd_wr.write) begin
      cmd_rdata <= cmd_wr.data & ~(8'h01 << error_reset_pos);
    end
  end

  // ****************************************
  // error flags
  // ****************************************
  logic parity_q;
  logic framing_q;
  logic overrun_q;

  // new errors win over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      parity_q <= 1'b0;
      framing_q <= 1'b0;
      overrun_q <= 1'b0;
    end else begin
      if (events.parity_err && rx_en) begin
        parity_q <= 1'b1;
      end else if (error_reset || !rx_en || events.rx_char) begin
        parity_q <= 1'b0;
      end
      if (events.framing_err && rx_en) begin
        framing_q <= 1'b1;
      end else if (error_reset || !rx_en || cmd_rd) begin
        framing_q <= 1'b0;
      end
      if (events.overrun_err && rx_en) begin
        overrun_q <= 1'b1;
      end else if (error_reset || !rx_en) begin
        overrun_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // ready flags
  // ****************************************
  logic rx_ready_q;
  logic tx_ready_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_ready_q <= 1'b0;
    end else if (!rx_en) begin
      rx_ready_q <= 1'b0;
    end else if (events.rx_char) begin
      rx_ready_q <= 1'b1;
    end else if (events.rx_read) begin
      rx_ready_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_ready_q <= 1'b0;
    end else if (!tx_en) begin
      tx_ready_q <= 1'b0;
    end else if (events.tx_empty) begin
      tx_ready_q <= 1'b1;
    end else if (events.thr_write) begin
      tx_ready_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_rdata <= 8'h00;
    end else begin
      status_rdata <= 8'h00;
      status_rdata[framing_pos] <= framing_q;
      status_rdata[overrun_pos] <= overrun_q;
      status_rdata[parity_pos] <= parity_q;
      status_rdata[receive_ready_pos] <= rx_ready_q;
      status_rdata[transmit_ready_pos] <= tx_ready_q;
    end
  end

  // ****************************************
  // modem controls and interrupt gate
  // ****************************************
  logic irq_src;

  // controller interrupt only counts for enabled directions
  assign irq_src = controller_irq && ((rx_en && rx_ready_q) ||
                   (tx_en && tx_ready_q));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
      host_irq <= 1'b0;
    end else begin
      rts_n <= !command_q[rts_pos];
      dtr_n <= !command_q[dtr_pos];
      // gate follows bit 5; the conflicting bit 3 reading is not used
      host_irq <= irq_src && command_q[rts_pos];
    end
  end

  // ****************************************
  // line steering per mode
  // ****************************************
  logic txd_d;
  logic rxc_d;

  always_comb begin
    txd_d = 1'b1;
    rxc_d = 1'b1;
    unique case (mode)
      mode_normal: begin
        txd_d = tx_en ? tx_serial : 1'b1;
        rxc_d = rx_serial;
      end
      mode_auto_echo: begin
        txd_d = rx_serial;
        rxc_d = rx_serial;
      end
      mode_local_loop: begin
        txd_d = 1'b1;
        rxc_d = tx_serial;
      end
      mode_remote_loop: begin
        // line is echoed; receiver sees idle
        txd_d = rx_serial;
        rxc_d = 1'b1;
      end
    endcase
    if (command_q[force_break_pos]) begin
      txd_d = 1'b0;
    end
    if (!rx_en) begin
      rxc_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_txd <= 1'b1;
      rx_to_core <= 1'b1;
      steer <= '0;
    end else begin
      line_txd <= txd_d;
      rx_to_core <= rxc_d;
      steer.mode <= mode;
      steer.receiver_enable <= rx_en;
      steer.transmitter_enable <= tx_en;
      steer.force_break_ctl <= command_q[force_break_pos];
    end
  end

endmodule
`default_nettype wire

// ==== core/serial_command_pkg.sv ====
/*
  Package for the serial command register block: bit positions, mode
  encodings, reset values and the carrier structs shared by the block.
  Assumes nothing of its surroundings beyond a SystemVerilog tool.
*/
`default_nettype none
package serial_command_pkg;

  // ****************************************
  // command register fields
  // ****************************************
  localparam int unsigned mode_hi_pos = 7;
  localparam int unsigned mode_lo_pos = 6;
  localparam int unsigned rts_pos = 5;
  localparam int unsigned error_reset_pos = 4;
  localparam int unsigned force_break_pos = 3;
  localparam int unsigned receiver_enable_pos = 2;
  localparam int unsigned dtr_pos = 1;
  localparam int unsigned transmitter_enable_pos = 0;
  localparam logic [7:0] command_reset = 8'h00;
  localparam logic [7:0] command_base_value = 8'h30;

  // ****************************************
  // status flag positions
  // ****************************************
  localparam int unsigned framing_pos = 5;
  localparam int unsigned overrun_pos = 4;
  localparam int unsigned parity_pos = 3;
  localparam int unsigned receive_ready_pos = 1;
  localparam int unsigned transmit_ready_pos = 0;

  typedef enum logic [1:0] {
    mode_normal = 2'h0,
    mode_auto_echo = 2'h1,
    mode_local_loop = 2'h2,
    mode_remote_loop = 2'h3
  } op_mode_type;

  // write port of the command register
  typedef struct packed {
    logic write;
    logic [7:0] data;
  } command_write_type;

  // error and ready events from the receiver and transmitter cores
  typedef struct packed {
    logic parity_err;
    logic framing_err;
    logic overrun_err;
    logic rx_char;
    logic tx_empty;
    logic thr_write;
    logic rx_read;
  } serial_events_type;

  // steering that the command register applies to the datapath
  typedef struct packed {
    op_mode_type mode;
    logic receiver_enable;
    logic transmitter_enable;
    logic force_break_ctl;
  } serial_steer_type;

endpackage
`default_nettype wire

// ==== tb/mouse_model.sv ====
/* mouse stand-in driving the receive line.
   assumes send is a one-clock pulse. */
`timescale 1ns/10ps
`default_nettype none
module mouse_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic send,
  output logic rx_serial
);
  logic [2:0] cnt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_q <= 3'h0;
    else if (send) cnt_q <= 3'h4;
    else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
  end
  // mark level between frames, as a pulled-up line
  assign rx_serial = (cnt_q == 3'h0);
endmodule
`default_nettype wire

// ==== tb/serial_command_props.sv ====
/* checker on the command block's ports.
   assumes bind from tb. */
`timescale 1ns/10ps
`default_nettype none
module serial_command_props
  import serial_command_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire command_write_type cmd_wr,
  input wire logic [7:0] cmd_rdata,
  input wire logic [7:0] status_rdata,
  input wire serial_steer_type steer,
  input wire logic line_txd,
  input wire logic rts_n,
  input wire logic dtr_n,
  input wire logic host_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_RB: assert property (cmd_wr.write |=>
    cmd_rdata == ($past(cmd_wr.data) & 8'hEF)) else $error("readback");
  AST_B4: assert property (!cmd_rdata[4]) else $error("bit4");
  AST_MODE: assert property (cmd_wr.write |-> ##2
    steer.mode == $past(cmd_wr.data[7:6], 2)) else $error("mode");
  AST_RTS: assert property (cmd_wr.write |-> ##2
    rts_n == !$past(cmd_wr.data[5], 2)) else $error("rts");
  AST_DTR: assert property (cmd_wr.write |-> ##2
    dtr_n == !$past(cmd_wr.data[1], 2)) else $error("dtr");
  AST_BRK: assert property (steer.force_break_ctl |->
    !line_txd) else $error("break");
  AST_IRQ: assert property (rts_n && $past(rts_n) |->
    !host_irq) else $error("irq gate");
  AST_RX: assert property (!steer.receiver_enable &&
    !$past(steer.receiver_enable) |-> !status_rdata[1]) else $error("rx");
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
/* self-checking bench for the command block.
   assumes mouse_model and the props checker. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import serial_command_pkg::*;
  logic clk, rst, cmd_rd, controller_irq, tx_serial, send, rx_serial;
  command_write_type cmd_wr;
  serial_events_type events;
  logic [7:0] cmd_rdata, status_rdata;
  serial_steer_type steer;
  logic line_txd, rts_n, dtr_n, host_irq, rx_to_core;
  int errors, samples_checked;
  serial_command_control i_serial_command_control (.clk(clk), .rst(rst),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .events(events),
    .controller_irq(controller_irq), .tx_serial(tx_serial),
    .rx_serial(rx_serial), .cmd_rdata(cmd_rdata),
    .status_rdata(status_rdata), .steer(steer), .line_txd(line_txd),
    .rts_n(rts_n), .dtr_n(dtr_n), .host_irq(host_irq),
    .rx_to_core(rx_to_core));
  mouse_model i_mouse_model (.clk(clk), .rst(rst), .send(send),
    .rx_serial(rx_serial));
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [7:0] d);
    @(posedge clk);
    cmd_wr <= '{1'b1, d};
    @(posedge clk);
    cmd_wr.write <= 1'b0;
    tick(3);
  endtask
  // one-clock pulses: mouse send, status read, core events
  task automatic ev(logic [8:0] m);
    @(posedge clk);
    {send, cmd_rd, events} <= m;
    @(posedge clk);
    {send, cmd_rd, events} <= 9'h000;
    tick(3);
  endtask
  task automatic summarize();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic t_modes();
    logic [1:0] m;
    for (int k = 0; k < 4; k++) begin
      m = 2'(k);
      wr({m, m[0], 3'h4, m[1], 1'b0});
      chk(cmd_rdata, {m, m[0], 3'h0, m[1], 1'b0});
      chk({steer.mode, rts_n, dtr_n, 4'h0},
        {m, ~m[0], ~m[1], 4'h0});
    end
  endtask
  task automatic t_err();
    wr(8'h20);
    ev(9'h008);
    chk(status_rdata & 8'h02, 8'h00);
    wr(8'h24);
    ev(9'h018);
    chk(status_rdata & 8'h12, 8'h12);
    ev(9'h060);
    chk(status_rdata & 8'h28, 8'h28);
    ev(9'h080);
    chk(status_rdata & 8'h10, 8'h10);
    chk(status_rdata & 8'h28, 8'h08);
    ev(9'h008);
    chk(status_rdata & 8'h08, 8'h00);
    ev(9'h048);
    chk(status_rdata & 8'h08, 8'h08);
    wr(8'h34);
    chk(status_rdata & 8'h38, 8'h00);
    ev(9'h010);
    wr(8'h20);
    chk(status_rdata & 8'h12, 8'h00);
  endtask
  task automatic t_irq();
    @(posedge clk);
    controller_irq <= 1'b1;
    wr(8'h21);
    ev(9'h004);
    chk({status_rdata[0], host_irq, 6'h0}, 8'hC0);
    @(posedge clk);
    controller_irq <= 1'b0;
    tick(3);
    chk({7'h0, host_irq}, 8'h00);
    @(posedge clk);
    controller_irq <= 1'b1;
    wr(8'h01);
    chk({6'h0, rts_n, host_irq}, 8'h02);
    wr(8'h20);
    chk(status_rdata & 8'h01, 8'h00);
    wr(8'h24);
    ev(9'h008);
    chk({status_rdata[1], host_irq, 6'h0}, 8'hC0);
    ev(9'h001);
    chk({status_rdata[1], host_irq, 6'h0}, 8'h00);
  endtask
  task automatic t_line();
    wr(8'h38);
    chk({7'h0, line_txd}, 8'h00);
    wr(8'h34);
    chk({7'h0, line_txd}, 8'h01);
    ev(9'h100);
    chk({7'h0, rx_to_core}, 8'h00);
    wr(8'hF4);
    ev(9'h100);
    chk({6'h0, line_txd, rx_to_core}, 8'h01);
  endtask
  task automatic t_loop();
    wr(8'h25);
    @(posedge clk);
    tx_serial <= 1'b0;
    tick(3);
    chk({6'h0, line_txd, rx_to_core}, 8'h01);
    wr(8'h24);
    chk({6'h0, line_txd, rx_to_core}, 8'h03);
    wr(8'hA5);
    chk({6'h0, line_txd, rx_to_core}, 8'h02);
    wr(8'hA1);
    chk({6'h0, line_txd, rx_to_core}, 8'h03);
    @(posedge clk);
    tx_serial <= 1'b1;
    wr(8'h65);
    ev(9'h100);
    chk({6'h0, line_txd, rx_to_core}, 8'h00);
  endtask
  // reset in mid-run must drop every control back to idle
  task automatic t_reset();
    wr(8'h25);
    @(posedge clk);
    rst <= 1'b1;
    tick(2);
    chk(cmd_rdata | status_rdata, 8'h00);
    chk({rts_n, dtr_n, line_txd, host_irq, rx_to_core, 3'h0}, 8'hE8);
    @(posedge clk);
    rst <= 1'b0;
    tick(2);
    chk({3'h0, steer}, 8'h00);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {send, cmd_rd, controller_irq} = 3'h0;
    tx_serial = 1'b1;
    cmd_wr = '0;
    events = '0;
    errors = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    chk({rts_n, dtr_n, line_txd, host_irq, rx_to_core, 3'h0}, 8'hE8);
    chk(cmd_rdata | status_rdata, 8'h00);
    t_modes();
    t_err();
    t_irq();
    t_line();
    t_loop();
    t_reset();
    summarize();
  end
endmodule
bind serial_command_control serial_command_props i_props (.clk(clk),
  .rst(rst), .cmd_wr(cmd_wr), .cmd_rdata(cmd_rdata),
  .status_rdata(status_rdata), .steer(steer), .line_txd(line_txd),
  .rts_n(rts_n), .dtr_n(dtr_n), .host_irq(host_irq));
`default_nettype wire
